// ===== rtl/watchdog_pkg.sv
// Package with register map, field layout and timing constants of the watchdog
package watchdog_pkg;
  // Register byte addresses (printed offsets are not all word aligned)
  localparam logic [7:0] CTRL_INDEX = 8'h24;
  localparam logic [7:0] STAT_INDEX = 8'h25;
  localparam logic [11:0] CTRL_ADDR = {2'h0, CTRL_INDEX, 2'h0};
  localparam logic [11:0] STAT_ADDR = {2'h0, STAT_INDEX, 2'h0};
  // Field layout and reset values
  localparam int ACT_BIT = 7;
  localparam int TOP_BIT = 6;
  localparam int FLAG_BIT = 0;
  localparam logic [7:0] CTRL_RESET = 8'h7f;
  localparam logic [6:0] COUNT_RESET = 7'h7f;
  // Timing
  localparam int STEP_CYCLES = 49152;
  localparam int CLK_PERIOD_NS = 100;
  localparam int RESET_PULSE_NS = 500;
  localparam int RESET_PULSE_CYCLES = (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef struct packed {
    logic act;
    logic [6:0] count;
  } ctrl_t;
endpackage

// ===== rtl/watchdog_reset_timer.sv
// Watchdog countdown with AXI4-Lite register access and reset pulse output
//
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/1ps
module watchdog_reset_timer import watchdog_pkg::*; #(
  parameter int STEP_LEN = STEP_CYCLES,
  parameter int PULSE_LEN = RESET_PULSE_CYCLES
) (
  // Clock and system reset
  input wire logic aclk,
  input wire logic aresetn,
  // Power on/off reset, active low, clears the flag
  input wire logic por_n,
  // Core status
  input wire logic halt_exec,
  input wire logic wait_mode,
  // Reset request to the reset block, active low
  output logic wdg_reset_n,
  // AXI4-Lite write address
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  ctrl_t ctrl_q;
  logic flag_q;
  logic [15:0] pre_q;
  logic [3:0] pulse_q;
  logic aw_held_q, w_held_q;
  logic [11:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic wr_fire, ctrl_wr, stat_wr, step, trig;
  logic [6:0] count_next;
  logic [11:0] wa;
  logic [31:0] wd;
  logic [3:0] ws;

  // Address and data may come in either order
  assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
  assign s_axi_wready = !w_held_q && !s_axi_bvalid;
  assign wa = aw_held_q ? awaddr_q : s_axi_awaddr;
  assign wd = w_held_q ? wdata_q : s_axi_wdata;
  assign ws = w_held_q ? wstrb_q : s_axi_wstrb;
  assign wr_fire = (aw_held_q || (s_axi_awvalid && s_axi_awready)) &&
                   (w_held_q || (s_axi_wvalid && s_axi_wready));
  assign ctrl_wr = wr_fire && wa == CTRL_ADDR && ws[0];
  assign stat_wr = wr_fire && wa == STAT_ADDR && ws[0];

  // Hold whichever half of the write arrives first
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= 12'h000;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else if (wr_fire) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
    end
  end

  // Write response, error for unmapped addresses
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (wa == CTRL_ADDR || wa == STAT_ADDR) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read channel, one cycle latency; status bits 7..1 read zero
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      if (s_axi_araddr == CTRL_ADDR) begin
        s_axi_rdata <= {24'h000000, ctrl_q};
      end else if (s_axi_araddr == STAT_ADDR) begin
        s_axi_rdata <= {31'h0, flag_q};
      end else begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Free-running machine-cycle prescaler, never restarted by writes; wait mode ignored
  assign step = pre_q == 16'(STEP_LEN - 1);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pre_q <= 16'h0000;
    end else if (step) begin
      pre_q <= 16'h0000;
    end else begin
      pre_q <= pre_q + 16'h0001;
    end
  end

  // Countdown and activation; act is sticky until reset
  assign count_next = ctrl_q.count - 7'h01;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= CTRL_RESET;
    end else begin
      if (ctrl_wr) begin
        ctrl_q.count <= wd[TOP_BIT:0];
      end else if (step) begin
        ctrl_q.count <= count_next;
      end
      if (ctrl_wr && wd[ACT_BIT]) begin
        ctrl_q.act <= 1'b1;
      end
    end
  end

  // Reset triggers: rollover 40h->3Fh, software reset, halt while armed
  assign trig = (ctrl_q.act && step && !ctrl_wr && ctrl_q.count == 7'h40) ||
                (ctrl_wr && (ctrl_q.act || wd[ACT_BIT]) && !wd[TOP_BIT]) ||
                (ctrl_q.act && halt_exec);

  // Pulse stretcher; the reset it drives returns here as aresetn
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pulse_q <= 4'h0;
    end else if (trig) begin
      pulse_q <= 4'(PULSE_LEN);
    end else if (pulse_q != 4'h0) begin
      pulse_q <= pulse_q - 4'h1;
    end
  end
  assign wdg_reset_n = (pulse_q == 4'h0);

  // Flag survives system reset; cleared only by power reset or software; set wins
  always_ff @(posedge aclk) begin
    if (!por_n) begin
      flag_q <= 1'b0;
    end else if (trig) begin
      flag_q <= 1'b1;
    end else if (stat_wr && !wd[FLAG_BIT]) begin
      flag_q <= 1'b0;
    end
  end
endmodule

// ===== verification/watchdog_reset_timer_props.sv
// Port-level assertions for the watchdog timer
`timescale 1ns/1ps
module watchdog_reset_timer_props import watchdog_pkg::*; (
  // Clock, reset and reset request
  input wire logic aclk, aresetn, wdg_reset_n,
  // Write channels
  input wire logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // Read channels
  input wire logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready,
  input wire logic [31:0] s_axi_rdata
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Write accepted whole, then the forcing pattern on top of it
  sequence s_wr; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
  sequence s_kill; s_wr ##0 (s_axi_awaddr == CTRL_ADDR && s_axi_wstrb[0] && s_axi_wdata[7:6] == 2'h2); endsequence
  property p_bans; s_wr |=> s_axi_bvalid; endproperty
  property p_bblk; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
  property p_rans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && s_axi_rdata[31:8] == 24'h0; endproperty
  property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  property p_arblk; s_axi_rvalid |-> !s_axi_arready; endproperty
  property p_kill; s_kill |-> ##[1:2] !wdg_reset_n; endproperty
  // Pulse width is the rounded-up 500 ns at 100 ns per cycle
  property p_pulse; $fell(wdg_reset_n) |-> !wdg_reset_n [*5] ##1 wdg_reset_n; endproperty
  a_bans: assert property (p_bans) else $error("write response late");
  a_bblk: assert property (p_bblk) else $error("write taken during response");
  a_bhold: assert property (p_bhold) else $error("write response dropped");
  a_rans: assert property (p_rans) else $error("read answer late or upper bits set");
  a_rhold: assert property (p_rhold) else $error("read answer unstable");
  a_arblk: assert property (p_arblk) else $error("read taken during answer");
  a_kill: assert property (p_kill) else $error("forced reset missing");
  a_pulse: assert property (p_pulse) else $error("reset pulse width wrong");
endmodule
bind watchdog_reset_timer watchdog_reset_timer_props chk (.*);

// ===== verification/test_watchdog_reset_timer.sv
// Self-checking bench for the watchdog timer
`timescale 1ns/1ps
module test_watchdog_reset_timer import watchdog_pkg::*;;
  logic aclk = 0, aresetn = 0, por_n = 0, halt_exec = 0, wait_mode = 0, wdg_reset_n;
  logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [17:0] exp_q[$];
  logic [17:0] e;
  int mismatches = 0, checks_done = 0, cyc = 0, n, r;
  // Short step keeps expiry runs brief
  watchdog_reset_timer #(.STEP_LEN(8)) uut (.*);
  always #50 aclk = ~aclk;
  // Wait mode toggles at random throughout
  always @(posedge aclk) wait_mode <= 1'($urandom);
  task automatic chk(input logic ok);
    checks_done++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("Error %0t: result differs", $time);
    end
  endtask
  // Note format: response, byte mask, expected byte
  always @(posedge aclk) if (s_axi_rvalid && s_axi_rready) begin
    e = exp_q.pop_front();
    chk(s_axi_rresp === e[17:16] && (s_axi_rdata & {24'hffffff, e[15:8]}) === {24'h0, e[7:0]});
  end
  // Hang guard
  always @(posedge aclk) if (++cyc > 3000) begin
    mismatches++;
    report_and_stop();
  end
  task report_and_stop;
    $display("Checks %0d, mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] x = RESP_OKAY);
    bit pa = 1, pw = 1, pb = 1;
    @(posedge aclk);
    s_axi_awaddr <= a; s_axi_wdata <= {24'h0, d}; s_axi_awvalid <= 1; s_axi_wvalid <= 1; s_axi_bready <= 1;
    while (pb) begin
      @(posedge aclk);
      if (pa && s_axi_awready) begin pa = 0; s_axi_awvalid <= 0; end
      if (pw && s_axi_wready) begin pw = 0; s_axi_wvalid <= 0; end
      if (s_axi_bvalid) begin pb = 0; s_axi_bready <= 0; chk(s_axi_bresp === x); end
    end
  endtask
  task automatic rd(input logic [11:0] a, input logic [17:0] x);
    bit pa = 1, pr = 1;
    exp_q.push_back(x);
    @(posedge aclk);
    s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
    while (pr) begin
      @(posedge aclk);
      if (pa && s_axi_arready) begin pa = 0; s_axi_arvalid <= 0; end
      if (s_axi_rvalid) begin pr = 0; s_axi_rready <= 0; end
    end
  endtask
  task automatic rst(input logic p);
    @(posedge aclk);
    aresetn <= 0; por_n <= !p;
    repeat (2) @(posedge aclk);
    aresetn <= 1; por_n <= 1;
  endtask
  // Cycles until the reset request goes low, capped
  task automatic wrst(input int lim);
    n = 0;
    while (wdg_reset_n !== 1'b0 && n < lim) begin @(posedge aclk); n++; end
  endtask
  initial begin
    r = $urandom(32'h0e826b56);
    rst(1);
    rd(CTRL_ADDR, {RESP_OKAY, 16'hff7f});
    rd(STAT_ADDR, {RESP_OKAY, 16'hff00});
    rd(12'h0a0, {RESP_SLVERR, 16'hff00});
    wr(12'h0a0, 8'h00, RESP_SLVERR);
    wr(CTRL_ADDR, 8'h00);
    rd(CTRL_ADDR, {RESP_OKAY, 16'h8000});
    @(posedge aclk) halt_exec <= 1;
    wrst(6);
    halt_exec <= 0;
    chk(n == 6);
    wr(STAT_ADDR, 8'($urandom) | 8'h01);
    rd(STAT_ADDR, {RESP_OKAY, 16'hff00});
    r = $urandom % 4;
    wr(CTRL_ADDR, {2'h3, 6'(r)});
    wrst(60);
    chk(n >= 8 * r - 2 && n <= 8 * r + 12);
    rd(STAT_ADDR, {RESP_OKAY, 16'hff01});
    rst(0);
    rd(STAT_ADDR, {RESP_OKAY, 16'hff01});
    rd(CTRL_ADDR, {RESP_OKAY, 16'hff7f});
    wr(STAT_ADDR, 8'h00);
    rd(STAT_ADDR, {RESP_OKAY, 16'hff00});
    wr(CTRL_ADDR, 8'h80);
    wrst(3);
    chk(n <= 2);
    rst(1);
    wr(CTRL_ADDR, 8'hff);
    // One-cycle halt so the reset pulse is not retriggered
    @(posedge aclk) halt_exec <= 1;
    @(posedge aclk) halt_exec <= 0;
    wrst(4);
    chk(n <= 3);
    rst(1);
    repeat (6) begin wr(CTRL_ADDR, 8'hc2); wrst(10); chk(n == 10); end
    report_and_stop();
  end
endmodule
